// >>> bench/cht_host_model.sv
// two-wire bus host that reads and writes the tracker registers
`timescale 1ns/1ps
module cht_host_model (
  // clock
  input wire logic mclk_i,
  // bus pins
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  int nack_cnt = 0;

  // bus idles high, clock stands still between frames
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // half bit period, well above the four-cycle minimum
  task hp;
    repeat (8) @(posedge mclk_i);
  endtask

  // one bit from host; one bit from target
  task put(input logic b);
    sda_oe_o <= ~b;
    hp;
    scl_o <= 1'b1;
    hp;
    scl_o <= 1'b0;
  endtask

  task get(output logic b);
    sda_oe_o <= 1'b0;
    hp;
    scl_o <= 1'b1;
    hp;
    b = sda_i;
    scl_o <= 1'b0;
  endtask

  // frame edges
  task start;
    sda_oe_o <= 1'b0;
    hp;
    scl_o <= 1'b1;
    hp;
    sda_oe_o <= 1'b1;
    hp;
    scl_o <= 1'b0;
  endtask

  task stop;
    sda_oe_o <= 1'b1;
    hp;
    scl_o <= 1'b1;
    hp;
    sda_oe_o <= 1'b0;
    hp;
  endtask

  // byte out with ack check; byte in closed by nack
  task tx(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    if (a !== 1'b0) nack_cnt++;
  endtask

  task rx(output logic [7:0] d);
    logic a;
    for (int i = 0; i < 8; i++)
    begin
      get(a);
      d = {d[6:0], a};
    end
    put(1'b1);
  endtask

  // write byte; send byte then receive byte
  task wr(input logic [7:0] ad, input logic [7:0] v);
    start;
    tx({cht_pkg::TARGET_ADDR, 1'b0});
    tx(ad);
    tx(v);
    stop;
  endtask

  task rd(input logic [7:0] ad, output logic [7:0] v);
    start;
    tx({cht_pkg::TARGET_ADDR, 1'b0});
    tx(ad);
    stop;
    start;
    tx({cht_pkg::TARGET_ADDR, 1'b1});
    rx(v);
    stop;
  endtask

  // host view of a hottest pair read in the extended format: add 64 degrees
  function automatic logic [15:0] ext_abs(input logic [15:0] v);
    return v + 16'h4000;
  endfunction
endmodule

// >>> bench/tb.sv
// self-checking bench for the channel enable and hottest tracker
`timescale 1ns/1ps
module tb;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic en_pin_i = 1'b0;
  logic nv_ack_i = 1'b0;
  logic [7:0] nv_data_i = 8'h00;
  logic conv_done_i = 1'b0;
  logic [15:0] conv_result_i = 16'h0000;
  logic conv_diode_fault_i = 1'b0;
  cht_pkg::cht_temps_t ref_temp_i;
  wire scl, sda, sda_o, sda_oe_o, host_oe, nv_rd_o, nv_cfg_load_o, conv_start_o;
  wire [7:0] nv_addr_o;
  wire [2:0] conv_chan_o;
  wire [4:0] chan_on_o;
  wire [4:0] diode_fault_o;
  logic [15:0] rnd = 16'h0055;
  logic [15:0] hot_exp;
  logic [15:0] temp [5];
  logic [15:0] diff [5];
  logic [7:0] nv_en, nv_sel, rv, hi;
  logic [4:0] valid, expf, seen, exp_sel;
  logic [2:0] cnt = 3'h0;
  int n_mismatch = 0;
  int checked = 0;
  int pulses, nv_reads;

  always #4 mclk_i = ~mclk_i;
  // open-drain data line with pull-up
  assign sda = ~(host_oe | (sda_oe_o & ~sda_o));

  cht_host_model host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
  cht_tracker dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .en_pin_i(en_pin_i), .nv_rd_o(nv_rd_o),
    .nv_addr_o(nv_addr_o), .nv_ack_i(nv_ack_i), .nv_data_i(nv_data_i),
    .nv_cfg_load_o(nv_cfg_load_o), .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
    .conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
    .conv_diode_fault_i(conv_diode_fault_i), .ref_temp_i(ref_temp_i),
    .chan_on_o(chan_on_o), .diode_fault_o(diode_fault_o));

  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // largest signed difference over a channel mask, else the old value
  function logic [15:0] best(input logic [4:0] m, input logic [15:0] old);
    logic [15:0] b;
    logic any;
    b = old;
    any = 1'b0;
    for (int i = 0; i < 5; i++)
      if (m[i] && (!any || $signed(diff[i]) > $signed(b)))
      begin
        b = diff[i];
        any = 1'b1;
      end
    return b;
  endfunction

  // nonvolatile store answers one cycle after each request
  always @(posedge mclk_i)
  begin
    nv_ack_i <= 1'b0;
    nv_data_i <= ~nv_data_i;
    if (rst_b_i && nv_rd_o && !nv_ack_i)
    begin
      nv_ack_i <= 1'b1;
      nv_data_i <= (nv_addr_o == cht_pkg::NV_CHAN_ENABLE_ADDR) ? nv_en : nv_sel;
      nv_reads <= nv_reads + 1;
    end
    if (nv_cfg_load_o) pulses <= pulses + 1;
  end

  // conversion engine with random latency, result and diode fault
  always @(posedge mclk_i)
  begin
    conv_done_i <= 1'b0;
    conv_result_i <= ~conv_result_i;
    conv_diode_fault_i <= ~conv_diode_fault_i;
    if (conv_start_o && !conv_done_i)
    begin
      cnt <= cnt + 3'h1;
      if (cnt == rnd[2:0])
      begin
        rnd = lfsr(rnd);
        conv_done_i <= 1'b1;
        conv_result_i <= rnd;
        conv_diode_fault_i <= rnd[0] & rnd[5];
        temp[conv_chan_o] = rnd & cht_pkg::FRAC_MASK;
        diff[conv_chan_o] = (temp[conv_chan_o] - ref_temp_i[conv_chan_o]) & cht_pkg::FRAC_MASK;
        valid[conv_chan_o] = 1'b1;
        seen[conv_chan_o] = 1'b1;
        if (chan_on_o[conv_chan_o]) expf[conv_chan_o] |= rnd[0] & rnd[5];
        cnt <= 3'h0;
      end
    end
  end

  task results;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task reset_dut(input logic [7:0] e, input logic [7:0] s);
    nv_en = e;
    nv_sel = s;
    valid = 5'h00;
    expf = 5'h00;
    exp_sel = 5'h1f;
    hot_exp = 16'h0000;
    pulses = 0;
    nv_reads = 0;
    rst_b_i <= 1'b0;
    repeat (12) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
  endtask

  // convert for a while, then pause through the enable pin
  task run_pause;
    int k;
    seen = 5'h00;
    en_pin_i <= 1'b1;
    repeat (400) @(posedge mclk_i);
    en_pin_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    k = 0;
    while (conv_start_o !== 1'b0 && k < 50)
    begin
      @(posedge mclk_i);
      k++;
    end
    if (k == 50)
    begin
      n_mismatch++;
      results;
    end
  endtask

  // hottest pair and diode fault status after a run
  task check_hot;
    host.rd(cht_pkg::HOT_UPPER_OFF, hi);
    host.rd(cht_pkg::HOT_LOWER_OFF, rv);
    hot_exp = best(exp_sel & valid, hot_exp);
    cmp({hi, rv}, hot_exp);
    cmp(host.ext_abs({hi, rv}), hot_exp + 16'h4000);
    cmp({11'h000, diode_fault_o}, {11'h000, expf});
    host.rd(cht_pkg::DIODE_FAULT_OFF, rv);
    cmp({8'h00, rv}, {11'h000, expf});
    expf = 5'h00;
    cmp({11'h000, diode_fault_o}, 16'h0000);
  endtask

  // main sequence
  initial
  begin
    for (int i = 0; i < 5; i++)
    begin
      rnd = lfsr(rnd);
      ref_temp_i[i] = i[0] ? (rnd & cht_pkg::FRAC_MASK) : 16'h0000;
    end
    reset_dut(8'h9f, 8'h1f);
    host.rd(cht_pkg::CHAN_ENABLE_OFF, rv);
    cmp({8'h00, rv}, 16'h009f);
    host.rd(cht_pkg::HOT_SEL_OFF, rv);
    cmp({8'h00, rv}, 16'h001f);
    cmp(pulses[15:0], 16'h0001);
    run_pause;
    // disable first: faults of channels 1, 3, 4 must hold until the status read
    host.wr(cht_pkg::CHAN_ENABLE_OFF, 8'h85);
    cmp({11'h000, chan_on_o}, 16'h0005);
    check_hot;
    cmp({11'h000, seen}, 16'h001f);
    host.wr(cht_pkg::HOT_SEL_OFF, 8'h06);
    exp_sel = 5'h06;
    host.rd(cht_pkg::CHAN_ENABLE_OFF, rv);
    cmp({8'h00, rv}, 16'h0085);
    run_pause;
    check_hot;
    cmp({11'h000, seen}, 16'h0005);
    host.rd(cht_pkg::TEMP_BASE_OFF + 8'h02, hi);
    host.rd(cht_pkg::TEMP_BASE_OFF + 8'h03, rv);
    cmp({hi, rv}, temp[1]);
    reset_dut(8'h03, 8'h1f);
    host.rd(cht_pkg::CHAN_ENABLE_OFF, rv);
    cmp({8'h00, rv}, 16'h001f);
    cmp(pulses[15:0], 16'h0000);
    cmp(nv_reads[15:0], 16'h0001);
    cmp(host.nack_cnt[15:0], 16'h0000);
    results;
  end
endmodule

// >>> verilog/cht_pkg.sv
// shared constants and types for the channel enable and hottest tracker
package cht_pkg;

  // channel count and per-channel word array
  localparam int NUM_CHAN = 5;
  typedef logic [NUM_CHAN-1:0][15:0] cht_temps_t;

  // register offsets on the two-wire bus
  localparam logic [7:0] TEMP_BASE_OFF = 8'h02;
  localparam logic [7:0] TEMP_LAST_OFF = 8'h0b;
  localparam logic [7:0] CHAN_ENABLE_OFF = 8'h0e;
  localparam logic [7:0] HOT_SEL_OFF = 8'h1a;
  localparam logic [7:0] DIODE_FAULT_OFF = 8'h44;
  localparam logic [7:0] HOT_UPPER_OFF = 8'h45;
  localparam logic [7:0] HOT_LOWER_OFF = 8'h46;

  // nonvolatile store locations copied at power-up
  localparam logic [7:0] NV_CHAN_ENABLE_ADDR = 8'h8e;
  localparam logic [7:0] NV_HOT_SEL_ADDR = 8'h9a;

  // field positions, masks and reset values
  localparam int NV_LOAD_BIT = 7;
  localparam logic [7:0] CHAN_EN_RST = 8'h9f;
  localparam logic [7:0] CHAN_EN_MASK = 8'h9f;
  localparam logic [7:0] HOT_SEL_RST = 8'h1f;
  localparam logic [7:0] HOT_SEL_MASK = 8'h1f;
  localparam logic [15:0] FRAC_MASK = 16'hfff0;
  localparam logic [2:0] CHAN_RST = 3'h4;
  localparam logic [2:0] CHAN_TOP = 3'h4;

  // two-wire target
  localparam logic [6:0] TARGET_ADDR = 7'h4c;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_OUT_BIT = 4'h7;

  // tracker sequencer states
  typedef enum logic [4:0] {
    ST_NVF = 5'h01,
    ST_NVS = 5'h02,
    ST_PICK = 5'h04,
    ST_CONV = 5'h08,
    ST_HOT = 5'h10
  } cht_main_e;

  // two-wire target states
  typedef enum logic [8:0] {
    TS_IDLE = 9'h001,
    TS_ADDR = 9'h002,
    TS_AACK = 9'h004,
    TS_CMD = 9'h008,
    TS_CACK = 9'h010,
    TS_WDAT = 9'h020,
    TS_DACK = 9'h040,
    TS_RDAT = 9'h080,
    TS_RACK = 9'h100
  } cht_tgt_e;

endpackage

// >>> verilog/cht_smbus_target.sv
// two-wire byte target: write byte, read byte, send byte, receive byte
`timescale 1ns/1ps
module cht_smbus_target (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // register side
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i
);

  typedef struct packed {
    cht_pkg::cht_tgt_e state;
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic rw;
    logic [7:0] ptr;
    logic drive;
  } tgt_s;

  localparam tgt_s TGT_RST = '{state: cht_pkg::TS_IDLE, scl_s1: 1'b1, scl_s2: 1'b1,
                               scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
                               default: '0};

  tgt_s st_reg;
  tgt_s st_next;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // bus events, from the second sync stage onward only
  assign scl_rise = st_reg.scl_s2 & ~st_reg.scl_d;
  assign scl_fall = ~st_reg.scl_s2 & st_reg.scl_d;
  assign bus_start = st_reg.scl_s2 & st_reg.scl_d & st_reg.sda_d & ~st_reg.sda_s2;
  assign bus_stop = st_reg.scl_s2 & st_reg.scl_d & ~st_reg.sda_d & st_reg.sda_s2;

  // register-side strobes
  assign reg_wr_o = scl_fall & (st_reg.state == cht_pkg::TS_WDAT)
                    & (st_reg.cnt == cht_pkg::BITS_PER_BYTE);
  assign reg_rd_o = scl_fall & (st_reg.state == cht_pkg::TS_AACK) & st_reg.rw;
  assign reg_addr_o = st_reg.ptr;
  assign reg_wdata_o = st_reg.shift;
  assign sda_o = 1'b0;
  assign sda_oe_o = st_reg.drive;

  // bit and byte sequencing
  always_comb
  begin
    st_next = st_reg;
    st_next.scl_s1 = scl_i;
    st_next.scl_s2 = st_reg.scl_s1;
    st_next.scl_d = st_reg.scl_s2;
    st_next.sda_s1 = sda_i;
    st_next.sda_s2 = st_reg.sda_s1;
    st_next.sda_d = st_reg.sda_s2;
    if (bus_start)
    begin
      st_next.state = cht_pkg::TS_ADDR;
      st_next.cnt = 4'h0;
      st_next.drive = 1'b0;
    end
    else if (bus_stop)
    begin
      st_next.state = cht_pkg::TS_IDLE;
      st_next.drive = 1'b0;
    end
    else
    begin
      // sample incoming bits on the rising edge
      if (scl_rise && (st_reg.state == cht_pkg::TS_ADDR || st_reg.state == cht_pkg::TS_CMD
                       || st_reg.state == cht_pkg::TS_WDAT))
      begin
        st_next.shift = {st_reg.shift[6:0], st_reg.sda_s2};
        st_next.cnt = st_reg.cnt + 4'h1;
      end
      // change what we drive only while the clock is low
      if (scl_fall)
      begin
        case (st_reg.state)
          cht_pkg::TS_ADDR:
            if (st_reg.cnt == cht_pkg::BITS_PER_BYTE)
            begin
              if (st_reg.shift[7:1] == cht_pkg::TARGET_ADDR)
              begin
                st_next.drive = 1'b1;
                st_next.rw = st_reg.shift[0];
                st_next.state = cht_pkg::TS_AACK;
              end
              else
                st_next.state = cht_pkg::TS_IDLE;
            end
          cht_pkg::TS_AACK:
          begin
            st_next.cnt = 4'h0;
            if (st_reg.rw)
            begin
              st_next.shift = reg_rdata_i;
              st_next.drive = ~reg_rdata_i[7];
              st_next.state = cht_pkg::TS_RDAT;
            end
            else
            begin
              st_next.drive = 1'b0;
              st_next.state = cht_pkg::TS_CMD;
            end
          end
          cht_pkg::TS_CMD:
            if (st_reg.cnt == cht_pkg::BITS_PER_BYTE)
            begin
              st_next.ptr = st_reg.shift;
              st_next.drive = 1'b1;
              st_next.state = cht_pkg::TS_CACK;
            end
          cht_pkg::TS_CACK:
          begin
            st_next.cnt = 4'h0;
            st_next.drive = 1'b0;
            st_next.state = cht_pkg::TS_WDAT;
          end
          cht_pkg::TS_WDAT:
            if (st_reg.cnt == cht_pkg::BITS_PER_BYTE)
            begin
              st_next.drive = 1'b1;
              st_next.state = cht_pkg::TS_DACK;
            end
          cht_pkg::TS_RDAT:
            if (st_reg.cnt == cht_pkg::LAST_OUT_BIT)
            begin
              st_next.drive = 1'b0;
              st_next.state = cht_pkg::TS_RACK;
            end
            else
            begin
              st_next.shift = {st_reg.shift[6:0], 1'b0};
              st_next.drive = ~st_reg.shift[6];
              st_next.cnt = st_reg.cnt + 4'h1;
            end
          default:
          begin
            st_next.drive = 1'b0;
            st_next.state = cht_pkg::TS_IDLE;
          end
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      st_reg <= TGT_RST;
    else
      st_reg <= st_next;
  end

endmodule

// >>> verilog/cht_tracker.sv
// channel enable, conversion sequencing and hottest-channel tracking
`timescale 1ns/1ps
module cht_tracker (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // external enable pin
  input wire logic en_pin_i,
  // nonvolatile store read port
  output logic nv_rd_o,
  output logic [7:0] nv_addr_o,
  input wire logic nv_ack_i,
  input wire logic [7:0] nv_data_i,
  output logic nv_cfg_load_o,
  // conversion engine
  output logic conv_start_o,
  output logic [2:0] conv_chan_o,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_result_i,
  input wire logic conv_diode_fault_i,
  input wire cht_pkg::cht_temps_t ref_temp_i,
  // status to the rest of the device
  output logic [4:0] chan_on_o,
  output logic [4:0] diode_fault_o
);

  typedef struct packed {
    cht_pkg::cht_main_e state;
    logic en_s1;
    logic en_s2;
    logic [7:0] chan_en;
    logic [7:0] hot_sel;
    logic [2:0] chan;
    logic [4:0] dfault;
    logic [4:0] valid;
    cht_pkg::cht_temps_t temp;
    cht_pkg::cht_temps_t diff;
    logic [15:0] hottest;
    logic [7:0] shadow;
    logic [7:0] nv_addr;
    logic cfg_load;
    logic conv_start;
  } ctx_s;

  localparam ctx_s CTX_RST = '{state: cht_pkg::ST_NVF, chan_en: cht_pkg::CHAN_EN_RST,
                               hot_sel: cht_pkg::HOT_SEL_RST, chan: cht_pkg::CHAN_RST,
                               nv_addr: cht_pkg::NV_CHAN_ENABLE_ADDR, default: '0};

  ctx_s st_reg;
  ctx_s st_next;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic addr_is_temp;
  logic [2:0] addr_chan;
  logic [4:0] hot_mask;

  // channel number of a temperature register address
  function automatic logic [2:0] temp_chan(input logic [7:0] a);
    logic [7:0] off;
    off = a - cht_pkg::TEMP_BASE_OFF;
    return off[3:1];
  endfunction

  // next enabled channel after cur, wrapping local after remote 4
  function automatic logic [2:0] next_chan(input logic [4:0] en, input logic [2:0] cur);
    logic [2:0] pick;
    logic [2:0] idx;
    logic found;
    pick = cur;
    idx = cur;
    found = 1'b0;
    for (int k = 0; k < cht_pkg::NUM_CHAN; k++)
    begin
      idx = (idx == cht_pkg::CHAN_TOP) ? 3'h0 : idx + 3'h1;
      if (!found && en[idx])
      begin
        pick = idx;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  // signed maximum over the masked differences
  function automatic logic [15:0] hot_max(input cht_pkg::cht_temps_t d, input logic [4:0] m);
    logic [15:0] best;
    logic seen;
    best = 16'h0000;
    seen = 1'b0;
    for (int i = 0; i < cht_pkg::NUM_CHAN; i++)
    begin
      if (m[i] && (!seen || $signed(d[i]) > $signed(best)))
      begin
        best = d[i];
        seen = 1'b1;
      end
    end
    return best;
  endfunction

  // true when no masked difference exceeds h
  function automatic logic all_le(input logic [15:0] h, input cht_pkg::cht_temps_t d,
                                  input logic [4:0] m);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < cht_pkg::NUM_CHAN; i++)
    begin
      if (m[i] && $signed(d[i]) > $signed(h))
        ok = 1'b0;
    end
    return ok;
  endfunction

  // host access over the two-wire pins
  cht_smbus_target u_target (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .reg_addr_o(reg_addr),
    .reg_wr_o(reg_wr),
    .reg_wdata_o(reg_wdata),
    .reg_rd_o(reg_rd),
    .reg_rdata_i(reg_rdata)
  );

  // address decode and comparison mask
  assign addr_is_temp = (reg_addr >= cht_pkg::TEMP_BASE_OFF)
                        && (reg_addr <= cht_pkg::TEMP_LAST_OFF);
  assign addr_chan = temp_chan(reg_addr);
  assign hot_mask = st_reg.hot_sel[4:0] & st_reg.valid;

  // read mux; lower bytes come from the shadow taken at the upper read
  always_comb
  begin
    reg_rdata = 8'h00;
    if (addr_is_temp)
      reg_rdata = reg_addr[0] ? st_reg.shadow : st_reg.temp[addr_chan][15:8];
    else
    begin
      case (reg_addr)
        cht_pkg::CHAN_ENABLE_OFF: reg_rdata = st_reg.chan_en;
        cht_pkg::HOT_SEL_OFF: reg_rdata = st_reg.hot_sel;
        cht_pkg::DIODE_FAULT_OFF: reg_rdata = {3'h0, st_reg.dfault};
        cht_pkg::HOT_UPPER_OFF: reg_rdata = st_reg.hottest[15:8];
        cht_pkg::HOT_LOWER_OFF: reg_rdata = st_reg.shadow;
        default: reg_rdata = 8'h00;
      endcase
    end
  end

  // outputs
  assign nv_rd_o = (st_reg.state == cht_pkg::ST_NVF) || (st_reg.state == cht_pkg::ST_NVS);
  assign nv_addr_o = st_reg.nv_addr;
  assign nv_cfg_load_o = st_reg.cfg_load;
  assign conv_start_o = st_reg.conv_start;
  assign conv_chan_o = st_reg.chan;
  assign chan_on_o = st_reg.chan_en[4:0];
  assign diode_fault_o = st_reg.dfault;

  // power-up load, host access, conversion sequencing and hottest update
  always_comb
  begin
    st_next = st_reg;
    st_next.cfg_load = 1'b0;
    st_next.en_s1 = en_pin_i;
    st_next.en_s2 = st_reg.en_s1;
    // upper-byte reads freeze the lower byte for the following read
    if (reg_rd && reg_addr == cht_pkg::HOT_UPPER_OFF)
      st_next.shadow = st_reg.hottest[7:0];
    else if (reg_rd && addr_is_temp && !reg_addr[0])
      st_next.shadow = st_reg.temp[addr_chan][7:0];
    // read clears diode faults; a set in the same cycle wins below
    if (reg_rd && reg_addr == cht_pkg::DIODE_FAULT_OFF)
      st_next.dfault = 5'h00;
    if (reg_wr && reg_addr == cht_pkg::CHAN_ENABLE_OFF)
      st_next.chan_en = reg_wdata & cht_pkg::CHAN_EN_MASK;
    if (reg_wr && reg_addr == cht_pkg::HOT_SEL_OFF)
      st_next.hot_sel = reg_wdata & cht_pkg::HOT_SEL_MASK;
    case (st_reg.state)
      cht_pkg::ST_NVF:
        if (nv_ack_i)
        begin
          st_next.chan_en[cht_pkg::NV_LOAD_BIT] = nv_data_i[cht_pkg::NV_LOAD_BIT];
          if (nv_data_i[cht_pkg::NV_LOAD_BIT])
          begin
            st_next.chan_en = nv_data_i & cht_pkg::CHAN_EN_MASK;
            st_next.nv_addr = cht_pkg::NV_HOT_SEL_ADDR;
            st_next.state = cht_pkg::ST_NVS;
          end
          else
            st_next.state = cht_pkg::ST_PICK;
        end
      cht_pkg::ST_NVS:
        if (nv_ack_i)
        begin
          st_next.hot_sel = nv_data_i & cht_pkg::HOT_SEL_MASK;
          st_next.cfg_load = 1'b1;
          st_next.state = cht_pkg::ST_PICK;
        end
      cht_pkg::ST_PICK:
        // pin low or nothing enabled: idle, stored results untouched
        if (st_reg.en_s2 && (|st_reg.chan_en[4:0]))
        begin
          st_next.chan = next_chan(st_reg.chan_en[4:0], st_reg.chan);
          st_next.conv_start = 1'b1;
          st_next.state = cht_pkg::ST_CONV;
        end
      cht_pkg::ST_CONV:
        if (conv_done_i)
        begin
          st_next.temp[st_reg.chan] = conv_result_i & cht_pkg::FRAC_MASK;
          st_next.diff[st_reg.chan] = (conv_result_i - ref_temp_i[st_reg.chan])
                                      & cht_pkg::FRAC_MASK;
          st_next.valid[st_reg.chan] = 1'b1;
          if (conv_diode_fault_i && st_reg.chan_en[st_reg.chan])
            st_next.dfault[st_reg.chan] = 1'b1;
          st_next.conv_start = 1'b0;
          st_next.state = cht_pkg::ST_HOT;
        end
      cht_pkg::ST_HOT:
      begin
        if (|hot_mask)
          st_next.hottest = hot_max(st_reg.diff, hot_mask);
        st_next.state = cht_pkg::ST_PICK;
      end
      default:
        st_next.state = cht_pkg::ST_PICK;
    endcase
  end

  // state register
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      st_reg <= CTX_RST;
    else
      st_reg <= st_next;
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  // nonvolatile copy of bit 7 lands in the working register
  nv_flag_a: assert property ((st_reg.state == cht_pkg::ST_NVF) && nv_ack_i |=>
    st_reg.chan_en[7] == $past(nv_data_i[7]))
    else $error("load-enable bit not taken from nonvolatile copy");

  // blocked load goes straight to running, only bit 7 copied
  nv_block_a: assert property ((st_reg.state == cht_pkg::ST_NVF) && nv_ack_i
    && !nv_data_i[7] |=> (st_reg.state == cht_pkg::ST_PICK) && !nv_cfg_load_o
    && (nv_rd_o == 1'b0))
    else $error("configuration loaded while load enable was clear");

  // host write to the enable register
  en_write_a: assert property (reg_wr && reg_addr == cht_pkg::CHAN_ENABLE_OFF
    && !nv_rd_o |=> st_reg.chan_en == ($past(reg_wdata) & cht_pkg::CHAN_EN_MASK))
    else $error("channel enable write not applied");

  // host write to the selection register
  sel_write_a: assert property (reg_wr && reg_addr == cht_pkg::HOT_SEL_OFF
    && !nv_rd_o |=> st_reg.hot_sel == ($past(reg_wdata) & cht_pkg::HOT_SEL_MASK))
    else $error("selection write not applied");

  // conversions only start on enabled channels
  conv_skip_a: assert property ($rose(conv_start_o) |->
    (($past(st_reg.chan_en[4:0]) >> conv_chan_o) & 5'h01) == 5'h01)
    else $error("conversion started on a disabled channel");

  // no new diode fault on a disabled channel
  fault_gate_a: assert property ((st_reg.dfault & ~$past(st_reg.dfault)
    & ~$past(st_reg.chan_en[4:0])) == 5'h00)
    else $error("diode fault set on disabled channel");

  // fault bits fall only after a status read
  fault_hold_a: assert property ((|($past(st_reg.dfault) & ~st_reg.dfault)) |->
    $past(reg_rd && reg_addr == cht_pkg::DIODE_FAULT_OFF))
    else $error("fault bit cleared without a status read");

  // stored temperatures change only on a finished conversion
  temp_keep_a: assert property ((st_reg.temp != $past(st_reg.temp)) |->
    $past(conv_done_i && st_reg.state == cht_pkg::ST_CONV))
    else $error("temperature result changed without conversion");

  // difference is result minus reference of that channel
  diff_calc_a: assert property ((st_reg.state == cht_pkg::ST_CONV) && conv_done_i |=>
    st_reg.diff[st_reg.chan] == $past((conv_result_i - ref_temp_i[st_reg.chan])
    & cht_pkg::FRAC_MASK))
    else $error("channel difference wrong");

  // hottest is not below any selected difference
  hot_max_a: assert property ((st_reg.state == cht_pkg::ST_HOT) && (|hot_mask) |=>
    all_le(st_reg.hottest, st_reg.diff, $past(hot_mask)))
    else $error("hottest result below a selected channel");

  // hottest keeps its low nibble at zero
  hot_nib_a: assert property (st_reg.hottest[3:0] == 4'h0)
    else $error("hottest low bits not zero");

  // main scenarios
  conv_done_c: cover property ((st_reg.state == cht_pkg::ST_CONV) && conv_done_i);
  hot_upd_c: cover property ((st_reg.state == cht_pkg::ST_HOT) && (|hot_mask));
  fault_set_c: cover property ($rose(|st_reg.dfault));
  nv_block_c: cover property ((st_reg.state == cht_pkg::ST_NVF) && nv_ack_i && !nv_data_i[7]);

endmodule
